//--- verilog/rcz_pkg.sv
package rcz_pkg;
  localparam int ZONES = 15;
  localparam int CYL_W = 15;
  localparam logic [14:0] ZONE_TOP [ZONES] = '{
    15'h03c4, 15'h0866, 15'h0dfc, 15'h12b6, 15'h17e8, 15'h1f5e, 15'h24e0, 15'h2bca,
    15'h2f8a, 15'h312e, 15'h3476, 15'h385e, 15'h3df4, 15'h4114, 15'h4394};
  // Rates in units of 10 kB/s
  localparam logic [11:0] ZONE_RATE [ZONES] = '{
    12'hd74, 12'hd74, 12'hd74, 12'hd74, 12'hd0d, 12'hc6f, 12'hbf3, 12'hb37,
    12'had0, 12'ha9a, 12'ha32, 12'h9b0, 12'h8f8, 12'h891, 12'h7f4};
  localparam int TAPS       = 10;
  localparam int SMP_W      = 8;
  localparam int COEF_W     = 10;
  localparam logic [9:0] COEF_MAIN = 10'h040;
  localparam int ACC_W      = SMP_W + COEF_W + 4;
  localparam int EQ_SHIFT   = 6;
  localparam logic signed [7:0] EPR4_STEP = 8'sh10;
  localparam logic [9:0] MU = 10'h001;
  localparam int VIT_DEPTH  = 16;
  localparam int CODE_BITS  = 51;
  localparam int DATA_BITS  = 48;
  localparam int CODE_SUB   = 17;
  localparam int FRAMES     = 96;
  localparam int RECOV_LEN  = 32;
  localparam int MARK_WAIT  = 64;
  localparam int GRAY_BITS  = 16;
  localparam int GRAY_CELL  = 4;
  localparam int BURSTS     = 4;
  localparam int BURST_LEN  = 16;
  localparam int PAD_LEN    = 16;
  localparam int BURST_W    = 16;
  localparam int REV_W      = 24;
  localparam int PH_W       = 24;
  localparam real CLK_MHZ   = 100.0;
  localparam real SPIN_RPM  = 5400.0;
  localparam int PHASES_REV = 6;
  localparam int SPIN_TICKS = int'(60.0e6 * CLK_MHZ / (SPIN_RPM * PHASES_REV));
  localparam logic [23:0] SPIN_TARGET = SPIN_TICKS[23:0];
  typedef enum logic [2:0] {SF_RECOV, SF_MARK, SF_GRAY, SF_BURST, SF_PAD} rcz_frame_e;
endpackage

//--- verilog/rcz_read_channel.sv
`timescale 1ns/1ps
`default_nettype none
module rcz_read_channel #(
  parameter logic [rcz_pkg::REV_W-1:0] SPIN_TARGET = rcz_pkg::SPIN_TARGET
) (
  // Clock and reset
  input  wire logic                               core_clk,
  input  wire logic                               rst,
  // Microprocessor setup
  input  wire logic                               rateLoad,
  input  wire logic [rcz_pkg::PH_W-1:0]           rateWord,
  input  wire logic                               filtLoad,
  input  wire logic [7:0]                         cutoffIn,
  input  wire logic [7:0]                         boostIn,
  input  wire logic                               writeMode,
  output logic      [7:0]                         cutoffDac,
  output logic      [7:0]                         boostDac,
  output logic      [3:0]                         zone,
  output logic      [11:0]                        zoneRate,
  // Read path
  input  wire logic signed [rcz_pkg::SMP_W-1:0]   sample,
  output logic                                    readClkEn,
  output logic      [rcz_pkg::DATA_BITS-1:0]      nrzData,
  output logic                                    nrzValid,
  // Servo pins and bursts
  input  wire logic                               servo_mark_first,
  input  wire logic                               servo_mark_second,
  input  wire logic                               grayBitIn,
  input  wire logic signed [rcz_pkg::SMP_W-1:0]   burstSample,
  output logic                                    burst_sample_window,
  output logic      [rcz_pkg::BURSTS*rcz_pkg::BURST_W-1:0] burstLevel,
  output logic                                    burstValid,
  output logic      [rcz_pkg::CYL_W-1:0]          cylinder,
  output logic      [6:0]                         frameIdx,
  output logic                                    markMissing,
  // Spindle
  input  wire logic                               spinPhase,
  output logic                                    pumpCharge,
  output logic                                    pumpDischarge
);
  function automatic logic [3:0] firstZone(input logic [rcz_pkg::ZONES-1:0] hit);
    firstZone = 4'he;
    for (int i = rcz_pkg::ZONES - 1; i >= 0; i--) if (hit[i]) firstZone = 4'(i);
  endfunction

  // Setup registers from the microprocessor
  logic [rcz_pkg::PH_W-1:0] rate_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rate_q    <= '0;
      cutoffDac <= 8'h00;
      boostDac  <= 8'h00;
    end else begin
      if (rateLoad) rate_q <= rateWord;
      if (filtLoad) begin
        cutoffDac <= cutoffIn;
        boostDac  <= boostIn;
      end
    end
  end

  // Zone lookup on the demodulated cylinder
  logic [rcz_pkg::ZONES-1:0] zoneHit;
  genvar g;
  generate
    for (g = 0; g < rcz_pkg::ZONES; g++) begin : gZone
      assign zoneHit[g] = cylinder <= rcz_pkg::ZONE_TOP[g];
    end
  endgenerate
  wire [3:0] zoneSel = firstZone(zoneHit);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      zone     <= 4'h0;
      zoneRate <= 12'h000;
    end else begin
      zone     <= zoneSel;
      zoneRate <= rcz_pkg::ZONE_RATE[zoneSel];
    end
  end

  // Adaptive FIR equaliser, sign-sign LMS
  logic signed [rcz_pkg::SMP_W-1:0]  tap_q  [rcz_pkg::TAPS];
  logic signed [rcz_pkg::COEF_W-1:0] coef_q [rcz_pkg::TAPS];
  logic signed [rcz_pkg::ACC_W-1:0]  accSum;
  logic signed [rcz_pkg::SMP_W-1:0]  eq_q, target, eqErr;
  always_comb begin
    accSum = '0;
    for (int i = 0; i < rcz_pkg::TAPS; i++)
      accSum = accSum + rcz_pkg::ACC_W'(tap_q[i] * coef_q[i]);
  end
  wire signed [rcz_pkg::ACC_W-1:0] eqScaled = accSum >>> rcz_pkg::EQ_SHIFT;
  // Nearest EPR4 level; saturation keeps the slicer inside the five levels
  wire signed [rcz_pkg::SMP_W-1:0] eqNext = (eqScaled > 127) ? 8'sh7f :
                                            (eqScaled < -128) ? -8'sh80 : eqScaled[7:0];
  assign target = (eq_q > 3 * rcz_pkg::EPR4_STEP)  ? 8'sh40 :
                  (eq_q > rcz_pkg::EPR4_STEP)      ? 8'sh20 :
                  (eq_q < -3 * rcz_pkg::EPR4_STEP) ? -8'sh40 :
                  (eq_q < -rcz_pkg::EPR4_STEP)     ? -8'sh20 : 8'sh00;
  assign eqErr = eq_q - target;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      eq_q <= '0;
      for (int i = 0; i < rcz_pkg::TAPS; i++) begin
        tap_q[i]  <= '0;
        coef_q[i] <= (i == rcz_pkg::TAPS / 2) ? rcz_pkg::COEF_MAIN : '0;
      end
    end else if (readClkEn) begin
      tap_q[0] <= sample;
      eq_q     <= eqNext;
      for (int i = 1; i < rcz_pkg::TAPS; i++) tap_q[i] <= tap_q[i-1];
      for (int i = 0; i < rcz_pkg::TAPS; i++)
        if (!writeMode && eqErr != 0)
          coef_q[i] <= ((eqErr < 0) ^ (tap_q[i] < 0)) ? coef_q[i] + rcz_pkg::MU
                                                      : coef_q[i] - rcz_pkg::MU;
    end
  end

  // Data separator: NCO at the loaded rate, nudged by equaliser zero crossings
  logic [rcz_pkg::PH_W-1:0] phase_q;
  logic signed [rcz_pkg::SMP_W-1:0] eqPrev_q;
  wire zeroCross = (eq_q[7] != eqPrev_q[7]);
  wire signed [rcz_pkg::PH_W-1:0] phErr = rcz_pkg::PH_W'(eq_q) <<< 8;
  wire [rcz_pkg::PH_W:0] phSum = {1'b0, phase_q} + {1'b0, rate_q};
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      phase_q   <= '0;
      eqPrev_q  <= '0;
      readClkEn <= 1'b0;
    end else begin
      readClkEn <= phSum[rcz_pkg::PH_W];
      if (readClkEn) eqPrev_q <= eq_q;
      if (!writeMode && readClkEn && zeroCross)
        phase_q <= phSum[rcz_pkg::PH_W-1:0] - phErr;
      else
        phase_q <= phSum[rcz_pkg::PH_W-1:0];
    end
  end

  // Two-state difference-metric Viterbi with survivor registers
  logic signed [rcz_pkg::SMP_W+1:0] dm_q;
  logic [rcz_pkg::VIT_DEPTH-1:0] surv0_q, surv1_q;
  wire signed [rcz_pkg::SMP_W+1:0] eqExt = (rcz_pkg::SMP_W+2)'(eq_q);
  wire take1 = (dm_q + eqExt) > 0;
  wire take0 = (dm_q + eqExt) < 0;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dm_q    <= '0;
      surv0_q <= '0;
      surv1_q <= '0;
    end else if (readClkEn && !writeMode) begin
      dm_q <= take1 ? -eqExt : (take0 ? -eqExt : dm_q);
      surv1_q <= {(take0 ? surv0_q[rcz_pkg::VIT_DEPTH-2:0] : surv1_q[rcz_pkg::VIT_DEPTH-2:0]), 1'b1};
      surv0_q <= {(take1 ? surv1_q[rcz_pkg::VIT_DEPTH-2:0] : surv0_q[rcz_pkg::VIT_DEPTH-2:0]), 1'b0};
    end
  end
  wire vitBit = dm_q[rcz_pkg::SMP_W+1] ? surv0_q[rcz_pkg::VIT_DEPTH-1]
                                       : surv1_q[rcz_pkg::VIT_DEPTH-1];

  // Code groups: every seventeenth bit is a code bit and is dropped
  logic [5:0] bitCnt_q;
  logic [4:0] subCnt_q;
  logic [rcz_pkg::DATA_BITS-1:0] grp_q;
  wire codeBit = (subCnt_q == 5'(rcz_pkg::CODE_SUB - 1));
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bitCnt_q <= '0;
      subCnt_q <= '0;
      grp_q    <= '0;
      nrzData  <= '0;
      nrzValid <= 1'b0;
    end else begin
      nrzValid <= 1'b0;
      if (readClkEn && !writeMode) begin
        subCnt_q <= codeBit ? 5'd0 : subCnt_q + 5'd1;
        if (!codeBit) grp_q <= {grp_q[rcz_pkg::DATA_BITS-2:0], vitBit};
        if (bitCnt_q == 6'(rcz_pkg::CODE_BITS - 1)) begin
          bitCnt_q <= '0;
          nrzData  <= grp_q;
          nrzValid <= 1'b1;
        end else bitCnt_q <= bitCnt_q + 6'd1;
      end
    end
  end

  // Pin synchronisers; a change counts once stages two and three agree
  logic [2:0] smk1S, smk2S, grayS, phS;
  logic smk1F, smk2F, grayF, phF, phF_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      {smk1S, smk2S, grayS, phS} <= '0;
      {smk1F, smk2F, grayF, phF, phF_q} <= '0;
    end else begin
      smk1S <= {smk1S[1:0], servo_mark_first};
      smk2S <= {smk2S[1:0], servo_mark_second};
      grayS <= {grayS[1:0], grayBitIn};
      phS   <= {phS[1:0], spinPhase};
      if (smk1S[1] == smk1S[2]) smk1F <= smk1S[2];
      if (smk2S[1] == smk2S[2]) smk2F <= smk2S[2];
      if (grayS[1] == grayS[2]) grayF <= grayS[2];
      if (phS[1] == phS[2]) phF <= phS[2];
      phF_q <= phF;
    end
  end

  // Servo frame sequencer
  rcz_pkg::rcz_frame_e st_q;
  logic [7:0] cnt_q;
  logic [4:0] grayIdx_q;
  logic [1:0] burstIdx_q;
  logic [rcz_pkg::GRAY_BITS-1:0] gray_q;
  logic seenFirst_q;
  logic signed [rcz_pkg::BURST_W-1:0] acc_q [rcz_pkg::BURSTS];
  wire [rcz_pkg::GRAY_BITS-1:0] grayBin;
  assign grayBin[rcz_pkg::GRAY_BITS-1] = gray_q[rcz_pkg::GRAY_BITS-1];
  generate
    for (g = rcz_pkg::GRAY_BITS - 2; g >= 0; g--) begin : gGray
      assign grayBin[g] = grayBin[g+1] ^ gray_q[g];
    end
  endgenerate
  // Unsigned view so a full-scale negative sample rectifies to +128, not to a sign-extended word
  wire [rcz_pkg::BURST_W-1:0] rectified =
    rcz_pkg::BURST_W'($unsigned(burstSample[7] ? -burstSample : burstSample));
  wire cellEnd = (cnt_q == 8'(rcz_pkg::GRAY_CELL - 1));
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q <= rcz_pkg::SF_RECOV;
      {cnt_q, grayIdx_q, burstIdx_q, gray_q, seenFirst_q} <= '0;
      for (int i = 0; i < rcz_pkg::BURSTS; i++) acc_q[i] <= '0;
      {burst_sample_window, burstValid, markMissing} <= '0;
      burstLevel <= '0;
      cylinder   <= '0;
      frameIdx   <= '0;
    end else begin
      cnt_q      <= cnt_q + 8'd1;
      burstValid <= 1'b0;
      case (st_q)
        rcz_pkg::SF_RECOV: if (cnt_q == 8'(rcz_pkg::RECOV_LEN - 1)) begin
          st_q <= rcz_pkg::SF_MARK;
          cnt_q <= '0;
          seenFirst_q <= 1'b0;
        end
        rcz_pkg::SF_MARK: begin
          if (smk1F) seenFirst_q <= 1'b1;
          // Both mark halves must be seen, first then second, to start the reference
          if (seenFirst_q && smk2F) begin
            st_q <= rcz_pkg::SF_GRAY;
            cnt_q <= '0;
            grayIdx_q <= '0;
            markMissing <= 1'b0;
          end else if (cnt_q == 8'(rcz_pkg::MARK_WAIT - 1)) begin
            st_q <= rcz_pkg::SF_PAD;
            cnt_q <= '0;
            markMissing <= 1'b1;
          end
        end
        rcz_pkg::SF_GRAY: if (cellEnd) begin
          cnt_q  <= '0;
          gray_q <= {gray_q[rcz_pkg::GRAY_BITS-2:0], grayF};
          grayIdx_q <= grayIdx_q + 5'd1;
          if (grayIdx_q == 5'(rcz_pkg::GRAY_BITS - 1)) begin
            st_q <= rcz_pkg::SF_BURST;
            burstIdx_q <= '0;
            burst_sample_window <= 1'b1;
            for (int i = 0; i < rcz_pkg::BURSTS; i++) acc_q[i] <= '0;
          end
        end
        rcz_pkg::SF_BURST: begin
          if (burst_sample_window)
            acc_q[burstIdx_q] <= acc_q[burstIdx_q] + rectified;
          if (cnt_q == 8'(rcz_pkg::BURST_LEN - 1)) begin
            cnt_q <= '0;
            burstIdx_q <= burstIdx_q + 2'd1;
            if (burstIdx_q == 2'(rcz_pkg::BURSTS - 1)) begin
              st_q <= rcz_pkg::SF_PAD;
              burst_sample_window <= 1'b0;
            end
          end
        end
        rcz_pkg::SF_PAD: if (cnt_q == 8'(rcz_pkg::PAD_LEN - 1)) begin
          st_q  <= rcz_pkg::SF_RECOV;
          cnt_q <= '0;
          frameIdx <= (frameIdx == 7'(rcz_pkg::FRAMES - 1)) ? 7'd0 : frameIdx + 7'd1;
          if (!markMissing) begin
            cylinder   <= grayBin[rcz_pkg::CYL_W-1:0];
            burstLevel <= {acc_q[3], acc_q[2], acc_q[1], acc_q[0]};
            burstValid <= 1'b1;
          end
        end
        default: st_q <= rcz_pkg::SF_RECOV;
      endcase
    end
  end

  // Spindle: time between phase interrupts against the 5400 rpm target
  logic [rcz_pkg::REV_W-1:0] per_q, pump_q;
  wire phEdge = phF & ~phF_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      per_q <= '0;
      pump_q <= '0;
      pumpCharge <= 1'b0;
      pumpDischarge <= 1'b0;
    end else if (phEdge) begin
      // The edge cycle itself counts, so per_q equals the full period at the next edge
      per_q <= 24'h000001;
      // Slow turn gives a long period: charge; fast turn: discharge, for the difference
      pumpCharge    <= per_q > SPIN_TARGET;
      pumpDischarge <= per_q < SPIN_TARGET;
      pump_q <= (per_q > SPIN_TARGET) ? per_q - SPIN_TARGET
                                      : SPIN_TARGET - per_q;
    end else begin
      if (per_q != '1) per_q <= per_q + 1'b1;
      if (pump_q != '0) pump_q <= pump_q - 1'b1;
      if (pump_q <= 24'h000001) begin
        pumpCharge    <= 1'b0;
        pumpDischarge <= 1'b0;
      end
    end
  end
endmodule // rcz_read_channel
`default_nettype wire

//--- sim/rcz_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module rcz_far_model (
  // Clock and bench control
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        markOn,
  input  wire logic        grayLevel,
  // Frame events seen from the channel
  input  wire logic        burstValid,
  input  wire logic        markMissing,
  input  wire logic        burst_sample_window,
  // Head side
  output logic             servo_mark_first,
  output logic             servo_mark_second,
  output logic             grayBitIn,
  output logic signed [7:0] burstSample
);
  logic [7:0] cnt;
  logic       missSeen;
  // Restart at each burstValid and at each change of markMissing; long first mark tolerates an early restart
  always @(negedge core_clk or posedge rst) begin
    if (rst) begin
      cnt <= 8'h00;
      missSeen <= 1'b0;
      burstSample <= 8'h00;
    end else begin
      missSeen <= markMissing;
      cnt <= (burstValid || missSeen != markMissing) ? 8'h00 : cnt + 8'h01;
      // Outside the window the line toggles, so stale values never look valid
      burstSample <= burst_sample_window ? 8'hfb : {8{cnt[0]}};
    end
  end
  assign servo_mark_first  = markOn && cnt >= 8'h28 && cnt <= 8'h37;
  assign servo_mark_second = markOn && cnt >= 8'h3a && cnt <= 8'h3d;
  // A constant level reads the same whatever the cell alignment
  assign grayBitIn = grayLevel;
endmodule // rcz_far_model
`default_nettype wire

//--- sim/rcz_read_channel_sva.sv
`timescale 1ns/1ps
`default_nettype none
module rcz_read_channel_sva (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Setup and zone
  input  wire logic        filtLoad,
  input  wire logic [7:0]  cutoffIn,
  input  wire logic [7:0]  boostIn,
  input  wire logic [7:0]  cutoffDac,
  input  wire logic [7:0]  boostDac,
  input  wire logic [3:0]  zone,
  input  wire logic [11:0] zoneRate,
  // Servo, data, spindle
  input  wire logic [14:0] cylinder,
  input  wire logic        burst_sample_window,
  input  wire logic        burstValid,
  input  wire logic [6:0]  frameIdx,
  input  wire logic        nrzValid,
  input  wire logic        pumpCharge,
  input  wire logic        pumpDischarge
);
  logic [7:0] winCnt_q;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  function automatic logic [3:0] zoneOf(input logic [14:0] c);
    logic [3:0] z;
    z = 4'hf;
    for (int i = 14; i >= 0; i--) begin
      if (c <= rcz_pkg::ZONE_TOP[i]) begin
        z = 4'(i);
      end
    end
    return z;
  endfunction
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      winCnt_q <= 8'h00;
    end else begin
      winCnt_q <= burst_sample_window ? winCnt_q + 8'h01 : 8'h00;
    end
  end
  dac_load_a: assert property (filtLoad |=>
    cutoffDac == $past(cutoffIn) && boostDac == $past(boostIn)) else $error("dac load");
  dac_hold_a: assert property (!filtLoad |=> $stable(cutoffDac) && $stable(boostDac))
    else $error("dac changed");
  zone_map_a: assert property ($stable(cylinder)[*2] ##0 cylinder <= 15'h4394
    |-> zone == zoneOf(cylinder)) else $error("zone lookup");
  zone_rate_a: assert property (!$past(rst) && $stable(zone)
    |-> zoneRate == rcz_pkg::ZONE_RATE[zone]) else $error("zone rate");
  window_len_a: assert property ($fell(burst_sample_window) |-> winCnt_q == 8'h40)
    else $error("window length");
  pad_gap_a: assert property ($fell(burst_sample_window) |-> ##[14:18] burstValid)
    else $error("frame end");
  frame_step_a: assert property ($changed(frameIdx) |-> frameIdx ==
    (($past(frameIdx) == 7'h5f) ? 7'h00 : $past(frameIdx) + 7'h01)) else $error("frame step");
  nrz_pulse_a: assert property (nrzValid |=> !nrzValid) else $error("word pulse");
  pump_excl_a: assert property (!(pumpCharge && pumpDischarge)) else $error("pump");
  cover property (burstValid);
  cover property (nrzValid);
  cover property (pumpDischarge);
  cover property (pumpCharge);
endmodule // rcz_read_channel_sva
`default_nettype wire

//--- sim/rcz_read_channel_bench.sv
`timescale 1ns/1ps
`default_nettype none
module rcz_read_channel_bench;
  logic core_clk = 1'b0, rst = 1'b1, rateLoad = 1'b0, filtLoad = 1'b0, writeMode = 1'b0;
  logic [23:0] rateWord = 24'h000000;
  logic [7:0] cutoffIn = 8'h00, boostIn = 8'h00, cutoffDac, boostDac;
  logic signed [7:0] sample = 8'h00, burstSample;
  logic markOn = 1'b1, grayLevel = 1'b1, spinPhase = 1'b0;
  logic markA, markB, grayBit, readClkEn, nrzValid, win, burstValid, markMissing;
  logic pumpCharge, pumpDischarge;
  logic [3:0] zone;
  logic [11:0] zoneRate;
  logic [47:0] nrzData;
  logic [63:0] burstLevel;
  logic [14:0] cylinder;
  logic [6:0] frameIdx;
  int errorCnt = 0, nTests = 0, cycles = 0;
  // Short spindle target keeps the run brief; the logic is the same at the real figure
  rcz_read_channel #(.SPIN_TARGET(24'h000190)) i_rcz_read_channel (.core_clk(core_clk),
    .rst(rst), .rateLoad(rateLoad),
    .rateWord(rateWord), .filtLoad(filtLoad), .cutoffIn(cutoffIn), .boostIn(boostIn),
    .writeMode(writeMode), .cutoffDac(cutoffDac), .boostDac(boostDac), .zone(zone),
    .zoneRate(zoneRate), .sample(sample), .readClkEn(readClkEn), .nrzData(nrzData),
    .nrzValid(nrzValid), .servo_mark_first(markA), .servo_mark_second(markB),
    .grayBitIn(grayBit), .burstSample(burstSample), .burst_sample_window(win),
    .burstLevel(burstLevel), .burstValid(burstValid), .cylinder(cylinder),
    .frameIdx(frameIdx), .markMissing(markMissing), .spinPhase(spinPhase),
    .pumpCharge(pumpCharge), .pumpDischarge(pumpDischarge));
  rcz_far_model i_rcz_far_model (.core_clk(core_clk), .rst(rst), .markOn(markOn),
    .grayLevel(grayLevel), .burstValid(burstValid), .markMissing(markMissing),
    .burst_sample_window(win), .servo_mark_first(markA), .servo_mark_second(markB),
    .grayBitIn(grayBit), .burstSample(burstSample));
  always #5 core_clk = ~core_clk;
  always @(negedge core_clk) sample <= sample + 8'sh25;
  task automatic stopTest;
    $display("Comparisons %0d, mismatches %0d", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 90000) begin
      errorCnt++;
      stopTest;
    end
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
    nTests++;
    if (seen !== exp) begin
      errorCnt++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic waitHigh(ref logic sig);
    int i;
    i = 0;
    do begin
      tick(1);
      i++;
    end while (sig !== 1'b1 && i < 400);
    chk(sig, 1'b1, "wait ran out");
  endtask
  task automatic tDac;
    filtLoad = 1'b1;
    {cutoffIn, boostIn} = 16'h3cc3;
    tick(1);
    {cutoffIn, boostIn} = 16'ha55a;
    chk({cutoffDac, boostDac}, 16'h3cc3, "dac first");
    tick(1);
    filtLoad = 1'b0;
    cutoffIn = 8'h00;
    chk({cutoffDac, boostDac}, 16'ha55a, "dac second");
    tick(3);
    chk({cutoffDac, boostDac}, 16'ha55a, "dac hold");
    $display("test dac done");
  endtask
  task automatic tRate;
    int n, w;
    logic [47:0] held;
    held = '0;
    rateWord = 24'h400000;
    rateLoad = 1'b1;
    tick(1);
    rateLoad = 1'b0;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      w = 0;
      tick(8);
      repeat (2040) begin
        tick(1);
        n += (readClkEn === 1'b1);
        w += (nrzValid === 1'b1);
      end
      chk(n >= 505 && n <= 515, 1'b1, "enable rate");
      chk(w, (k == 0) ? 10 : 0, "word count");
      writeMode = 1'b1;
      if (k == 0) held = nrzData;
    end
    chk(nrzData, held, "data hold");
    writeMode = 1'b0;
    $display("test rate done");
  endtask
  task automatic tGray(input logic lvl, input logic [14:0] cyl, input int z);
    logic [6:0] f;
    grayLevel = lvl;
    waitHigh(burstValid);
    f = frameIdx;
    waitHigh(burstValid);
    chk(frameIdx, (f == 7'h5f) ? 7'h00 : f + 7'h01, "frame index");
    chk(cylinder, cyl, "cylinder");
    chk(burstLevel, {4{16'h0050}}, "burst levels");
    chk(markMissing, 1'b0, "mark flag");
    tick(3);
    chk(zone, z, "zone");
    chk(zoneRate, rcz_pkg::ZONE_RATE[z], "zone rate");
    $display("test gray done");
  endtask
  task automatic tMiss;
    waitHigh(burstValid);
    markOn = 1'b0;
    grayLevel = 1'b1;
    waitHigh(markMissing);
    markOn = 1'b1;
    chk(cylinder, 15'h0000, "kept cylinder");
    waitHigh(burstValid);
    tick(2);
    chk(markMissing, 1'b0, "mark back");
    chk(cylinder, 15'h2aaa, "new cylinder");
    $display("test miss done");
  endtask
  task automatic spinStep(input int per, input int chg, input int dis, input logic doChk);
    int c, d;
    c = 0;
    d = 0;
    for (int i = 0; i < per; i++) begin
      spinPhase = (i < 8);
      tick(1);
      c += (pumpCharge === 1'b1);
      d += (pumpDischarge === 1'b1);
    end
    if (doChk) begin
      chk(c, chg, "charge time");
      chk(d, dis, "discharge time");
    end
    $display("test spin step done");
  endtask
  initial begin
    tick(2);
    rst = 1'b0;
    tick(1);
    tDac;
    tRate;
    tGray(1'b1, 15'h2aaa, 7);
    tGray(1'b0, 15'h0000, 0);
    tMiss;
    spinStep(400, 0, 0, 1'b0);
    spinStep(400, 0, 0, 1'b0);
    spinStep(300, 0, 0, 1'b1);
    spinStep(420, 0, 100, 1'b1);
    spinStep(300, 20, 0, 1'b1);
    stopTest;
  end
endmodule // rcz_read_channel_bench
bind rcz_read_channel rcz_read_channel_sva i_rcz_read_channel_sva (.core_clk(core_clk),
  .rst(rst), .filtLoad(filtLoad), .cutoffIn(cutoffIn), .boostIn(boostIn),
  .cutoffDac(cutoffDac), .boostDac(boostDac), .zone(zone), .zoneRate(zoneRate),
  .cylinder(cylinder), .burst_sample_window(burst_sample_window), .burstValid(burstValid),
  .frameIdx(frameIdx), .nrzValid(nrzValid), .pumpCharge(pumpCharge),
  .pumpDischarge(pumpDischarge));
`default_nettype wire
